/* File: rtl/port_pin_event_regs.svh */
/*
 * Register offsets, field positions and reset values of the port pin control block.
 * Assumes a 32-bit AHB-Lite bus with word-aligned single transfers.
 */
`ifndef PORT_PIN_EVENT_REGS_SVH
`define PORT_PIN_EVENT_REGS_SVH

// ****************************************************************
// Offsets
// ****************************************************************
`define OFS_MASK_SEL  8'h80
`define OFS_MASK_CFG  8'h84
`define OFS_MASK_EVT  8'h88
`define OFS_FLAGS     8'h8C
`define OFS_FILT_EN   8'h90
`define OFS_FILT_CTRL 8'h94
`define OFS_PIN_STATE 8'h98

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define POS_CFG_REGION 7
`define MSK_CFG_LOW    32'h0000FFFF
`define MSK_CFG_EVT    32'h000F0000
`define MSK_CFG_WRITE  32'h000F8F77
`define POS_FILT_SRC   0
`define POS_FILT_WIDTH 1
`define RST_CFG        32'h00000000
`define RST_WORD       32'h00000000
`define RST_FILT_WIDTH 5'h00

`endif

/* File: rtl/port_pin_event_pkg.sv */
/*
 * Types of the port pin control block.
 * Uses literal encodings and does not need the register header.
 */
package port_pin_event_pkg;

    typedef enum logic [3:0] {
        event_off      = 4'b0000,
        dma_rise       = 4'b0001,
        dma_fall       = 4'b0010,
        dma_either     = 4'b0011,
        flag_rise      = 4'b0101,
        flag_fall      = 4'b0110,
        flag_either    = 4'b0111,
        irq_level_low  = 4'b1000,
        irq_rise       = 4'b1001,
        irq_fall       = 4'b1010,
        irq_either     = 4'b1011,
        irq_level_high = 4'b1100,
        trig_high      = 4'b1101,
        trig_low       = 4'b1110
    } event_t;

    typedef enum logic [3:0] {
        func_off_or_analog = 4'b0000,
        func_general_io    = 4'b0001
    } func_t;

    typedef enum logic {
        drive_weak   = 1'b0,
        drive_strong = 1'b1
    } drive_t;

    typedef struct packed {
        logic [11:0] rsv_hi;
        logic [3:0]  evt;
        logic        lock;
        logic [2:0]  rsv_b;
        logic [3:0]  func;
        logic        rsv_a;
        logic        drive;
        logic        open_drain;
        logic        passive_filt;
        logic        rsv_0;
        logic        slew;
        logic [1:0]  pull;
    } pin_cfg_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } bus_phase_t;

endpackage

/* File: rtl/port_pin_event_control.sv */
/*
 * Per-port pin configuration, digital filter and event/flag logic behind an AHB-Lite slave.
 * Assumes one master, HREADY_IN tied to HREADYOUT_OUT, DMA_DONE_IN on the bus clock.
 */
`timescale 1ns/1ps
`include "port_pin_event_regs.svh"

module port_pin_event_control
    import port_pin_event_pkg::*;
#(
    parameter int PINS = 32,
    parameter int FW   = 5
) (
    // Clock, reset and enable
    input  wire logic              CLK_SYS_IN,
    input  wire logic              RESETN_IN,
    input  wire logic              CE_IN,
    // AHB-Lite slave
    input  wire logic              HSEL_IN,
    input  wire logic [31:0]       HADDR_IN,
    input  wire logic [1:0]        HTRANS_IN,
    input  wire logic              HWRITE_IN,
    input  wire logic [2:0]        HSIZE_IN,
    input  wire logic [31:0]       HWDATA_IN,
    input  wire logic              HREADY_IN,
    output logic      [31:0]       HRDATA_OUT,
    output logic                   HREADYOUT_OUT,
    output logic                   HRESP_OUT,
    // Pins, low power clock and DMA
    input  wire logic [PINS-1:0]   PINS_IN,
    input  wire logic              LOW_POWER_OSC_CLOCK_IN,
    input  wire logic [PINS-1:0]   DMA_DONE_IN,
    // Events and pad control
    output logic                   IRQ_OUT,
    output logic      [PINS-1:0]   DMA_REQ_OUT,
    output logic      [PINS-1:0]   TRIG_OUT,
    output logic      [PINS-1:0]   DRIVE_STRONG_OUT,
    output logic      [PINS-1:0]   GPIO_SEL_OUT
);

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    bus_phase_t      dph;
    logic            acc;
    logic            wr_en;
    logic [31:0]     rd_mux;
    pin_cfg_t        cfg [PINS];
    logic [31:0]     mask_sel;
    logic [31:0]     filt_en;
    logic            filt_src;
    logic [FW-1:0]   filt_width;
    logic [PINS-1:0] flag;
    logic [PINS-1:0] next_flag;
    logic [PINS-1:0] set_ev;
    logic [PINS-1:0] clr;
    logic [PINS-1:0] is_dma;
    logic [PINS-1:0] is_irq;
    logic [PINS-1:0] filt;
    logic [PINS-1:0] rise;
    logic [PINS-1:0] fall;

    assign acc   = HSEL_IN & HREADY_IN & HTRANS_IN[1];
    assign wr_en = dph.valid & dph.write & HREADYOUT_OUT;

    // Reads take one wait state so that read data always comes from a flop.
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            dph           <= '0;
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
            HRDATA_OUT    <= `RST_WORD;
        end else if (CE_IN) begin
            if (HREADY_IN) begin
                dph <= '{valid: acc, write: HWRITE_IN, addr: HADDR_IN[7:0]};
            end
            if (acc && !HWRITE_IN) begin
                HREADYOUT_OUT <= 1'b0;
            end else begin
                HREADYOUT_OUT <= 1'b1;
            end
            if (!HREADYOUT_OUT) begin
                HRDATA_OUT <= rd_mux;
            end
        end
    end

    always_comb begin
        rd_mux = `RST_WORD;
        if (!dph.addr[`POS_CFG_REGION]) begin
            rd_mux = cfg[dph.addr[6:2]];
        end else begin
            unique case (dph.addr)
                `OFS_MASK_SEL:  rd_mux = mask_sel;
                `OFS_FLAGS:     rd_mux = 32'(flag);
                `OFS_FILT_EN:   rd_mux = filt_en;
                `OFS_FILT_CTRL: rd_mux = 32'({filt_width, filt_src});
                `OFS_PIN_STATE: rd_mux = 32'(filt);
                default:        rd_mux = `RST_WORD;
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Takes the bits of d selected by m and MSK_CFG_WRITE; a locked word keeps its low half.
    function automatic pin_cfg_t merge(pin_cfg_t old, logic [31:0] d, logic [31:0] m);
        logic [31:0] wm;
        wm = m & `MSK_CFG_WRITE;
        if (old.lock) begin
            wm = wm & ~`MSK_CFG_LOW;
        end
        return pin_cfg_t'((old & ~wm) | (d & wm));
    endfunction

    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            for (int i = 0; i < PINS; i++) begin
                cfg[i] <= `RST_CFG;
            end
        end else if (CE_IN && wr_en) begin
            for (int i = 0; i < PINS; i++) begin
                if (!dph.addr[`POS_CFG_REGION] && dph.addr[6:2] == 5'(i)) begin
                    cfg[i] <= merge(cfg[i], HWDATA_IN, 32'hFFFFFFFF);
                end else if (dph.addr == `OFS_MASK_CFG && mask_sel[i]) begin
                    cfg[i] <= merge(cfg[i], HWDATA_IN, `MSK_CFG_LOW);
                end else if (dph.addr == `OFS_MASK_EVT && mask_sel[i]) begin
                    cfg[i] <= merge(cfg[i], HWDATA_IN, `MSK_CFG_EVT);
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            mask_sel   <= `RST_WORD;
            filt_en    <= `RST_WORD;
            filt_src   <= 1'b0;
            filt_width <= FW'(`RST_FILT_WIDTH);
        end else if (CE_IN && wr_en) begin
            unique case (dph.addr)
                `OFS_MASK_SEL: mask_sel <= HWDATA_IN;
                `OFS_FILT_EN:  filt_en <= HWDATA_IN;
                `OFS_FILT_CTRL: begin
                    filt_src   <= HWDATA_IN[`POS_FILT_SRC];
                    filt_width <= HWDATA_IN[`POS_FILT_WIDTH +: FW];
                end
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Pin path
    // ****************************************************************
    logic [PINS-1:0] pin_s1;
    logic [PINS-1:0] pin_s2;
    logic            osc_s1;
    logic            osc_s2;
    logic            osc_s3;
    logic            tick;

    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end else if (CE_IN) begin
            pin_s1 <= PINS_IN;
            pin_s2 <= pin_s1;
            osc_s1 <= LOW_POWER_OSC_CLOCK_IN;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end

    assign tick = filt_src ? (osc_s2 & ~osc_s3) : 1'b1;

    wire wr_flags = wr_en && dph.addr == `OFS_FLAGS;

    for (genvar i = 0; i < PINS; i++) begin : g_pin
        logic [FW-1:0] cnt;
        logic          fq;
        logic          pq;
        event_t        cond;

        always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
            if (!RESETN_IN) begin
                cnt <= '0;
                fq  <= 1'b0;
                pq  <= 1'b0;
            end else if (CE_IN) begin
                pq <= fq;
                if (!filt_en[i] || pin_s2[i] == fq) begin
                    fq  <= filt_en[i] ? fq : pin_s2[i];
                    cnt <= '0;
                end else if (tick) begin
                    if (cnt >= filt_width) begin
                        fq  <= pin_s2[i];
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
            end
        end

        assign cond    = event_t'(cfg[i].evt);
        assign filt[i] = fq;
        assign rise[i] = fq & ~pq;
        assign fall[i] = ~fq & pq;

        always_comb begin
            is_dma[i] = 1'b0;
            is_irq[i] = 1'b0;
            set_ev[i] = 1'b0;
            unique case (cond)
                event_off: set_ev[i] = 1'b0;
                dma_rise: begin
                    is_dma[i] = 1'b1;
                    set_ev[i] = rise[i];
                end
                dma_fall: begin
                    is_dma[i] = 1'b1;
                    set_ev[i] = fall[i];
                end
                dma_either: begin
                    is_dma[i] = 1'b1;
                    set_ev[i] = rise[i] | fall[i];
                end
                flag_rise:   set_ev[i] = rise[i];
                flag_fall:   set_ev[i] = fall[i];
                flag_either: set_ev[i] = rise[i] | fall[i];
                irq_level_low: begin
                    is_irq[i] = 1'b1;
                    set_ev[i] = ~fq;
                end
                irq_rise: begin
                    is_irq[i] = 1'b1;
                    set_ev[i] = rise[i];
                end
                irq_fall: begin
                    is_irq[i] = 1'b1;
                    set_ev[i] = fall[i];
                end
                irq_either: begin
                    is_irq[i] = 1'b1;
                    set_ev[i] = rise[i] | fall[i];
                end
                irq_level_high: begin
                    is_irq[i] = 1'b1;
                    set_ev[i] = fq;
                end
                trig_high, trig_low: set_ev[i] = 1'b0;
                default: set_ev[i] = 1'b0;
            endcase
        end

        assign clr[i]       = (wr_flags & HWDATA_IN[i]) | (is_dma[i] & DMA_DONE_IN[i]);
        assign next_flag[i] = set_ev[i] | (flag[i] & ~clr[i]);

        always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
            if (!RESETN_IN) begin
                TRIG_OUT[i] <= 1'b0;
            end else if (CE_IN) begin
                TRIG_OUT[i] <= (cond == trig_high && fq) || (cond == trig_low && !fq);
            end
        end
    end

    // ****************************************************************
    // Flags and outputs
    // ****************************************************************
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            flag             <= '0;
            IRQ_OUT          <= 1'b0;
            DMA_REQ_OUT      <= '0;
            DRIVE_STRONG_OUT <= '0;
            GPIO_SEL_OUT     <= '0;
        end else if (CE_IN) begin
            flag        <= next_flag;
            IRQ_OUT     <= |(next_flag & is_irq);
            DMA_REQ_OUT <= next_flag & is_dma;
            for (int i = 0; i < PINS; i++) begin
                DRIVE_STRONG_OUT[i] <= cfg[i].drive == drive_strong;
                GPIO_SEL_OUT[i]     <= cfg[i].func == func_general_io;
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RESETN_IN);

    a_off_no_flag: assert property (CE_IN && g_pin[0].cond == event_off && !flag[0] |=> !flag[0])
        else $error("flag set with event off");
    a_dma_edge_req: assert property (CE_IN && g_pin[0].cond == dma_rise && rise[0] |=> DMA_REQ_OUT[0])
        else $error("no DMA request on rising edge");
    a_flag_no_irq: assert property (CE_IN && g_pin[0].cond == flag_either && (rise[0] || fall[0])
                                    && is_irq == '0 |=> flag[0] && !IRQ_OUT)
        else $error("flag mode raised interrupt or missed its edge");
    a_level_refire: assert property (CE_IN && g_pin[0].cond == irq_level_low && !filt[0] |=> flag[0])
        else $error("level flag not set again");
    a_dma_done_clr: assert property (CE_IN && is_dma[0] && DMA_DONE_IN[0] && !set_ev[0] |=> !flag[0])
        else $error("DMA completion did not clear flag");
    a_w1c_hold: assert property (CE_IN && flag[0] && !clr[0] |=> flag[0])
        else $error("flag lost without clear");
    a_irq_cause: assert property (IRQ_OUT |-> |flag)
        else $error("interrupt without flag");
    a_lock_hold: assert property (CE_IN && cfg[0].lock && wr_en && dph.addr == 8'h00
                                  |=> $stable(cfg[0][15:0]))
        else $error("locked config changed");
    a_trig_follow: assert property (CE_IN && g_pin[0].cond == trig_low |=> TRIG_OUT[0] == !$past(filt[0]))
        else $error("trigger output wrong");

    c_irq_edge: cover property (g_pin[0].cond == irq_rise ##1 IRQ_OUT);
    c_dma_done: cover property (DMA_REQ_OUT[0] ##[1:20] !DMA_REQ_OUT[0]);
    c_mask_cfg: cover property (wr_en && dph.addr == `OFS_MASK_CFG);

endmodule

/* File: dv/dma_pin_partner.sv */
/*
 * Stand-in for the DMA controller that serves the per-pin requests of the port.
 * Assumes the bus clock, and a request that drops one edge after its done pulse.
 */
`timescale 1ns/1ps

module dma_pin_partner (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // Control from the bench
    input  wire logic        enable_in,
    input  wire logic [3:0]  delay_in,
    // Request and completion
    input  wire logic [31:0] req_in,
    output logic      [31:0] done_out,
    output int               served_out
);
    logic [31:0] sel;
    int          cnt;
    int          gap;
    bit          busy;

    // Serve the lowest requesting pin after a delay, then leave time for the request to drop.
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_out   <= '0;
            served_out <= 0;
            busy       <= 0;
            gap        <= 0;
            cnt        <= 0;
            sel        <= '0;
        end else begin
            done_out <= '0;
            if (busy) begin
                if (cnt == 0) begin
                    done_out   <= sel;
                    served_out <= served_out + 1;
                    busy       <= 0;
                    gap        <= 2;
                end else begin
                    cnt <= cnt - 1;
                end
            end else if (gap != 0) begin
                gap <= gap - 1;
            end else if (enable_in && req_in != 0) begin
                sel  <= req_in & (~req_in + 32'h1);
                cnt  <= int'(delay_in);
                busy <= 1;
            end
        end
    end
endmodule

/* File: dv/port_pin_event_control_bench.sv */
/*
 * Self-checking bench of the port pin control block with a reference model of configs and flags.
 * Assumes the register header, one bus master and the DMA stand-in.
 */
`timescale 1ns/1ps
`include "port_pin_event_regs.svh"

module port_pin_event_control_bench;
    logic        clk = 0;
    logic        rst_n = 0;
    logic        osc = 0;
    logic [1:0]  htrans = 0;
    logic        hwrite = 0;
    logic [31:0] haddr = 0;
    logic [31:0] hwdata = 0;
    logic [31:0] pins = 0;
    logic        dma_en = 0;
    logic [3:0]  dly = 0;
    logic [31:0] hrdata, dma_req, trig, drv, gsel, done, r, m, d;
    logic        hready, hresp, irq;
    logic [31:0] cfg_m [32];
    int          errors = 0;
    int          checks_done = 0;
    int          served, p, c;
    bit          pv, fm;

    always #12.5 clk = ~clk;

    port_pin_event_control #(.PINS(32), .FW(5)) i_port_pin_event_control (
        .CLK_SYS_IN(clk), .RESETN_IN(rst_n), .CE_IN(1'b1), .HSEL_IN(1'b1), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
        .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .PINS_IN(pins),
        .LOW_POWER_OSC_CLOCK_IN(osc), .DMA_DONE_IN(done), .IRQ_OUT(irq), .DMA_REQ_OUT(dma_req),
        .TRIG_OUT(trig), .DRIVE_STRONG_OUT(drv), .GPIO_SEL_OUT(gsel));

    dma_pin_partner i_dma_pin_partner (.clk_in(clk), .resetn_in(rst_n), .enable_in(dma_en),
        .delay_in(dly), .req_in(dma_req), .done_out(done), .served_out(served));

    // ****************************************************************
    // Bus, model and comparison tasks
    // ****************************************************************
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] dw);
        @(posedge clk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= dw;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    // A locked word keeps its low half; the event field stays writable.
    task automatic model(input int q, input logic [31:0] dv, input logic [31:0] t);
        if (cfg_m[q][15]) t &= ~`MSK_CFG_LOW;
        cfg_m[q] = (cfg_m[q] & ~t) | (dv & t);
    endtask

    task automatic wcfg(input int q, input logic [31:0] dv);
        bus(1, 8'(q * 4), dv);
        model(q, dv, `MSK_CFG_WRITE);
    endtask

    task automatic cfg_all;
        logic [31:0] ed, eg;
        for (int q = 0; q < 32; q++) begin
            bus(0, 8'(q * 4), 0);
            chk("cfg", cfg_m[q], r);
            ed[q] = cfg_m[q][6];
            eg[q] = cfg_m[q][11:8] == 4'h1;
        end
        chk("drive", ed, drv);
        chk("gpio", eg, gsel);
    endtask

    task automatic observe;
        bus(0, `OFS_FLAGS, 0);
        chk("flags", 32'(fm) << p, r);
        chk("hresp", 0, {31'h0, hresp});
        chk("irq", {31'h0, fm && c inside {[8:12]}}, {31'h0, irq});
        chk("dma", 32'(fm && c inside {[1:3]}) << p, dma_req);
        chk("trig", 32'((c == 13 && pv) || (c == 14 && !pv)) << p, trig);
    endtask

    function automatic bit lvl(input int k, input bit v);
        return (k == 8 && !v) || (k == 12 && v);
    endfunction

    function automatic bit edg(input int k, input bit rise);
        if (!(k inside {[1:3], [5:7], [9:11]})) return 0;
        return rise ? (k % 4 != 2) : (k % 4 != 1);
    endfunction

    task automatic finish_test;
        $display("checks_done %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        void'($urandom(37484));
        for (int q = 0; q < 32; q++) cfg_m[q] = `RST_CFG;
        repeat (20) @(posedge clk);
        rst_n <= 1;
        cfg_all;
        bus(0, 8'hA0, 32'h0);
        chk("unmapped", 0, r);
        for (int k = 0; k < 2; k++) for (int q = 0; q < 32; q++) wcfg(q, $urandom);
        cfg_all;
        m = $urandom;
        d = $urandom;
        bus(1, `OFS_MASK_SEL, m);
        bus(1, `OFS_MASK_CFG, d);
        for (int q = 0; q < 32; q++) if (m[q]) model(q, d, `MSK_CFG_WRITE & `MSK_CFG_LOW);
        bus(1, `OFS_MASK_SEL, '1);
        bus(1, `OFS_MASK_EVT, 0);
        for (int q = 0; q < 32; q++) model(q, 0, `MSK_CFG_EVT);
        cfg_all;
        bus(1, `OFS_FLAGS, '1);
        bus(0, `OFS_FLAGS, 0);
        chk("flags", 0, r);
        // The first pass uses pin 0, which the design's assertions watch.
        for (int j = 0; j < 2; j++) for (c = 0; c < 16; c++) begin
            p = (j == 0) ? 0 : $urandom_range(31, 1);
            wcfg(p, 32'(c) << 16);
            bus(1, `OFS_FLAGS, '1);
            fm = lvl(c, 0);
            pv = 0;
            observe;
            pins[p] <= 1;
            pv = 1;
            repeat (8) @(posedge clk);
            fm |= edg(c, 1) | lvl(c, 1);
            observe;
            bus(1, `OFS_FLAGS, 0);
            observe;
            bus(1, `OFS_FLAGS, '1);
            fm = lvl(c, 1);
            observe;
            pins[p] <= 0;
            pv = 0;
            repeat (8) @(posedge clk);
            fm |= edg(c, 0) | lvl(c, 0);
            observe;
            wcfg(p, 0);
            bus(1, `OFS_FLAGS, '1);
        end
        dma_en <= 1;
        dly <= 4'($urandom_range(5, 0));
        for (int j = 0; j < 2; j++) begin
            p = (j == 0) ? 0 : $urandom_range(31, 1);
            wcfg(p, 32'h3 << 16);
            for (int k = 1; k < 3; k++) begin
                pins[p] <= k[0];
                repeat (30) @(posedge clk);
                bus(0, `OFS_FLAGS, 0);
                chk("flags", 0, r);
                chk("dma", 0, dma_req);
                chk("served", 2 * j + k, served);
            end
            wcfg(p, 0);
        end
        wcfg(p, 32'h5 << 16);
        d = $urandom;
        bus(1, `OFS_FILT_EN, d);
        bus(0, `OFS_FILT_EN, 0);
        chk("filt_en", d, r);
        bus(1, `OFS_FILT_EN, 32'h1 << p);
        bus(1, `OFS_FILT_CTRL, 32'h6);
        bus(1, `OFS_FLAGS, '1);
        pins[p] <= 1;
        repeat (2) @(posedge clk);
        pins[p] <= 0;
        repeat (12) @(posedge clk);
        bus(0, `OFS_FLAGS, 0);
        chk("flags", 0, r);
        pins[p] <= 1;
        repeat (10) @(posedge clk);
        bus(0, `OFS_FLAGS, 0);
        chk("flags", 32'h1 << p, r);
        bus(1, `OFS_FILT_CTRL, 32'h7);
        pins[p] <= 0;
        repeat (20) @(posedge clk);
        bus(0, `OFS_PIN_STATE, 0);
        chk("state", 32'h1 << p, r & (32'h1 << p));
        repeat (12) begin
            osc <= ~osc;
            repeat (3) @(posedge clk);
        end
        repeat (6) @(posedge clk);
        bus(0, `OFS_PIN_STATE, 0);
        chk("state", 0, r & (32'h1 << p));
        finish_test;
    end

    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        finish_test;
    end
endmodule
